// file: design/relay_out.sv
// Relay output control: matrix routing, latching, test forcing and direct pulses.
// Assumes internal signals on clk; the release pin is asynchronous and is synchronised.
`timescale 1ns/10ps
`include "relay_out_cfg.svh"
module relay_out #(
  parameter int TICK_CYC  = `TICK_CYCLES,
  parameter int FORCE_TCK = `FORCE_TICKS
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Register bus
  input  wire relay_out_pkg::axil_req_t bus_req,
  output relay_out_pkg::axil_rsp_t      bus_rsp,
  // Internal signals and release pin
  input  wire logic [15:0]              prot_sig,
  input  wire logic                     release_pin,
  // Relay drives and stage force flag
  output logic [3:0]                    trip_outputs,
  output logic                          alarm_output,
  output logic                          service_fault_output,
  output logic                          stage_force
);
  // Output index of each direct channel: alarm, trip three, trip four.
  localparam int DIR_IDX [3] = '{4, 2, 3};

  function automatic relay_out_pkg::reg_sel_t decode(input logic [31:0] a);
    relay_out_pkg::reg_sel_t s;
    s = relay_out_pkg::SEL_NONE;
    if (a == `OFF_CTRL) s = relay_out_pkg::SEL_CTRL;
    if (a == `OFF_LATCH) s = relay_out_pkg::SEL_LATCH;
    if (a == `OFF_FVAL) s = relay_out_pkg::SEL_FVAL;
    if (a == `OFF_STAT) s = relay_out_pkg::SEL_STAT;
    if (a == `OFF_DIRECT) s = relay_out_pkg::SEL_DIRECT;
    if (a >= `OFF_PULSE0 && a < `OFF_PULSE0 + 32'h0000_000C && a[1:0] == 2'h0)
      s = relay_out_pkg::SEL_PULSE;
    if (a >= `OFF_MAP0 && a < `OFF_MAP0 + 32'h0000_0018 && a[1:0] == 2'h0)
      s = relay_out_pkg::SEL_MAP;
    return s;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
    return r;
  endfunction

  // State.
  relay_out_pkg::axil_rsp_t rsp;
  relay_out_pkg::axil_rsp_t next_rsp;
  logic [1:0]  rel_sync;
  logic        force_on;
  logic        next_force_on;
  logic [14:0] force_cnt;
  logic [14:0] next_force_cnt;
  logic [16:0] tick_cnt;
  logic [16:0] next_tick_cnt;
  logic [5:0]  latch_cfg;
  logic [5:0]  next_latch_cfg;
  logic [5:0]  fval;
  logic [5:0]  next_fval;
  logic [5:0]  lat;
  logic [5:0]  next_lat;
  logic [5:0]  relay;
  logic [5:0]  next_relay;
  logic [2:0]  dir_on;
  logic [2:0]  next_dir_on;
  logic [15:0] map [6];
  logic [15:0] next_map [6];
  logic [13:0] dur [3];
  logic [13:0] next_dur [3];
  logic [13:0] pcnt [3];
  logic [13:0] next_pcnt [3];

  logic        wr;
  logic        rd;
  logic        tick;
  logic        rel;
  logic        rel_sw;
  logic [5:0]  src;
  logic [5:0]  dir_vec;
  logic [31:0] wdat;
  logic [2:0]  widx;
  relay_out_pkg::reg_sel_t wsel;

  assign wr   = bus_req.awvalid && rsp.awready;
  assign rd   = bus_req.arvalid && rsp.arready;
  assign tick = tick_cnt == 17'(TICK_CYC - 1);
  assign wsel = decode(bus_req.awaddr);
  assign widx = 3'((bus_req.awaddr - ((wsel == relay_out_pkg::SEL_MAP) ?
                                      `OFF_MAP0 : `OFF_PULSE0)) >> 2);
  assign rel_sw = wr && wsel == relay_out_pkg::SEL_CTRL && bus_req.wstrb[0] &&
                  bus_req.wdata[`CTRL_REL];
  assign rel  = rel_sync[1] || rel_sw;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_src
      assign src[gi] = |(map[gi] & prot_sig);
    end
  endgenerate

  always_comb
  begin
    dir_vec = 6'h00;
    for (int k = 0; k < 3; k++)
      dir_vec[DIR_IDX[k]] = dir_on[k];
  end

  // Bus handshake: address and data are taken together, one access at a time per direction.
  always_comb
  begin
    next_rsp = rsp;
    next_rsp.awready = 1'b0;
    next_rsp.wready = 1'b0;
    next_rsp.arready = 1'b0;
    if (!rsp.bvalid && !rsp.awready && bus_req.awvalid && bus_req.wvalid)
    begin
      next_rsp.awready = 1'b1;
      next_rsp.wready = 1'b1;
    end
    if (wr)
    begin
      next_rsp.bvalid = 1'b1;
      next_rsp.bresp = (wsel == relay_out_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    else if (rsp.bvalid && bus_req.bready)
      next_rsp.bvalid = 1'b0;
    if (!rsp.rvalid && !rsp.arready && bus_req.arvalid)
      next_rsp.arready = 1'b1;
    if (rd)
    begin
      next_rsp.rvalid = 1'b1;
      next_rsp.rresp = `RESP_OKAY;
      next_rsp.rdata = 32'h0000_0000;
      unique case (decode(bus_req.araddr))
        relay_out_pkg::SEL_CTRL:   next_rsp.rdata = 32'(force_on);
        relay_out_pkg::SEL_LATCH:  next_rsp.rdata = 32'(latch_cfg);
        relay_out_pkg::SEL_FVAL:   next_rsp.rdata = 32'(fval);
        relay_out_pkg::SEL_STAT:   next_rsp.rdata = 32'({dir_on, force_on, relay});
        relay_out_pkg::SEL_DIRECT: next_rsp.rdata = 32'(dir_on);
        relay_out_pkg::SEL_PULSE:
          next_rsp.rdata = 32'(dur[2'((bus_req.araddr - `OFF_PULSE0) >> 2)]);
        relay_out_pkg::SEL_MAP:
          next_rsp.rdata = 32'(map[3'((bus_req.araddr - `OFF_MAP0) >> 2)]);
        relay_out_pkg::SEL_NONE:   next_rsp.rresp = `RESP_SLVERR;
      endcase
    end
    else if (rsp.rvalid && bus_req.rready)
      next_rsp.rvalid = 1'b0;
  end

  // Relay core: configuration, forcing, latching and direct pulses.
  always_comb
  begin
    next_tick_cnt = tick ? 17'h0_0000 : tick_cnt + 17'h0_0001;
    next_force_on = force_on;
    next_force_cnt = force_cnt;
    next_latch_cfg = latch_cfg;
    next_fval = fval;
    next_dir_on = dir_on;
    next_map = map;
    next_dur = dur;
    next_pcnt = pcnt;
    wdat = 32'h0000_0000;
    if (force_on && tick)
    begin
      next_force_cnt = force_cnt - 15'h0001;
      if (force_cnt <= 15'h0001)
      begin
        next_force_on = 1'b0;
        next_fval = 6'h00;
      end
    end
    for (int k = 0; k < 3; k++)
      if (dir_on[k] && tick && dur[k] != `PULSE_INF)
      begin
        next_pcnt[k] = pcnt[k] - 14'h0001;
        if (pcnt[k] <= 14'h0001)
          next_dir_on[k] = 1'b0;
      end
    if (wr)
    begin
      unique case (wsel)
        relay_out_pkg::SEL_CTRL:
        begin
          wdat = merge(32'(force_on), bus_req.wdata, bus_req.wstrb);
          next_force_on = wdat[`CTRL_FORCE];
          next_force_cnt = 15'(FORCE_TCK);
          if (!wdat[`CTRL_FORCE])
            next_fval = 6'h00;
        end
        relay_out_pkg::SEL_LATCH:
        begin
          wdat = merge(32'(latch_cfg), bus_req.wdata, bus_req.wstrb);
          next_latch_cfg = wdat[5:0];
        end
        relay_out_pkg::SEL_FVAL:
        begin
          wdat = merge(32'(fval), bus_req.wdata, bus_req.wstrb);
          if (force_on)
            next_fval = wdat[5:0];
        end
        relay_out_pkg::SEL_DIRECT:
        begin
          wdat = merge(32'(dir_on), bus_req.wdata, bus_req.wstrb);
          for (int k = 0; k < 3; k++)
          begin
            next_dir_on[k] = wdat[k] && dur[k] != `PULSE_RST;
            next_pcnt[k] = dur[k];
          end
        end
        relay_out_pkg::SEL_PULSE:
        begin
          wdat = merge(32'(dur[widx[1:0]]), bus_req.wdata, bus_req.wstrb);
          next_dur[widx[1:0]] = (wdat[13:0] > `PULSE_INF) ? `PULSE_INF : wdat[13:0];
        end
        relay_out_pkg::SEL_MAP:
        begin
          wdat = merge(32'(map[widx]), bus_req.wdata, bus_req.wstrb);
          next_map[widx] = wdat[15:0];
        end
        default:
        begin
        end
      endcase
    end
    // A source that is active during release wins, so no trip is lost.
    next_lat = src | (lat & ~{6{rel}});
    for (int i = 0; i < 6; i++)
      next_relay[i] = latch_cfg[i] ? lat[i] : src[i];
    next_relay = force_on ? fval : (next_relay | dir_vec);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rsp <= '0;
      rel_sync <= 2'h0;
      tick_cnt <= 17'h0_0000;
      force_on <= 1'b0;
      force_cnt <= 15'h0000;
      latch_cfg <= 6'h00;
      fval <= 6'h00;
      lat <= 6'h00;
      relay <= 6'h00;
      dir_on <= 3'h0;
      map <= '{default: 16'h0000};
      dur <= '{default: `PULSE_RST};
      pcnt <= '{default: 14'h0000};
    end
    else
    begin
      rsp <= next_rsp;
      rel_sync <= {rel_sync[0], release_pin};
      tick_cnt <= next_tick_cnt;
      force_on <= next_force_on;
      force_cnt <= next_force_cnt;
      latch_cfg <= next_latch_cfg;
      fval <= next_fval;
      lat <= next_lat;
      relay <= next_relay;
      dir_on <= next_dir_on;
      map <= next_map;
      dur <= next_dur;
      pcnt <= next_pcnt;
    end
  end

  assign bus_rsp = rsp;
  assign trip_outputs = relay[3:0];
  assign alarm_output = relay[4];
  assign service_fault_output = relay[5];
  assign stage_force = force_on;

  sequence s_aw_take;
    bus_req.awvalid && rsp.awready;
  endsequence
  sequence s_stat_read;
    rd && decode(bus_req.araddr) == relay_out_pkg::SEL_STAT;
  endsequence

  property p_follow;
    @(posedge clk) disable iff (!rst_n)
      !force_on && !latch_cfg[0] |=> relay[0] == $past(src[0]);
  endproperty
  a_follow: assert property (p_follow) else $error("Unlatched relay not following.");
  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      !force_on && latch_cfg[1] && lat[1] |=> relay[1];
  endproperty
  a_hold: assert property (p_hold) else $error("Latched relay dropped.");
  property p_release;
    @(posedge clk) disable iff (!rst_n)
      rel && !src[0] |=> !lat[0];
  endproperty
  a_release: assert property (p_release) else $error("Release did not clear latch.");
  property p_ignore;
    @(posedge clk) disable iff (!rst_n)
      s_aw_take ##0 (wsel == relay_out_pkg::SEL_FVAL && !force_on) |=> $stable(fval);
  endproperty
  a_ignore: assert property (p_ignore) else $error("Forced value taken without flag.");
  property p_forced;
    @(posedge clk) disable iff (!rst_n)
      force_on |=> relay == $past(fval);
  endproperty
  a_forced: assert property (p_forced) else $error("Forced value not on relays.");
  property p_timeout;
    @(posedge clk) disable iff (!rst_n)
      force_on && tick && force_cnt == 15'h0001 && !wr |=> !force_on && fval == 6'h00;
  endproperty
  a_timeout: assert property (p_timeout) else $error("Override did not time out.");
  property p_pulse_end;
    @(posedge clk) disable iff (!rst_n)
      dir_on[0] && tick && pcnt[0] == 14'h0001 && dur[0] != `PULSE_INF && !wr
      |=> !dir_on[0];
  endproperty
  a_pulse_end: assert property (p_pulse_end) else $error("Pulse did not end.");
  property p_infinite;
    @(posedge clk) disable iff (!rst_n)
      dir_on[1] && dur[1] == `PULSE_INF && !wr |=> dir_on[1];
  endproperty
  a_infinite: assert property (p_infinite) else $error("Infinite pulse ended.");
  property p_status;
    @(posedge clk) disable iff (!rst_n)
      s_stat_read |=> rsp.rvalid && rsp.rdata[5:0] == $past(relay);
  endproperty
  a_status: assert property (p_status) else $error("Status read wrong.");
  property p_bresp;
    @(posedge clk) disable iff (!rst_n)
      s_aw_take |=> rsp.bvalid ##0 !rsp.awready;
  endproperty
  a_bresp: assert property (p_bresp) else $error("Write response missing.");
endmodule

// file: design/relay_out_cfg.svh
// Register offsets, field positions, reset values and timing counts of the relay output block.
// Assumes a 10 MHz clock and a 32-bit AXI4-Lite register bus.
//
// Operation
// - Matrix routes any internal signal to any relay.
// - Each relay selects latched or non-latched operation.
// - Non-latched follows source; latched holds until release.
// - One common release clears all latched relays.
// - Four trip statuses: 0 off, 1 energised.
// - Alarm status: 0 inactive, 1 active.
// - Service fault output status bit reported.
// - One test-override flag forces relays and stages.
// - Status writes ignored unless override flag set.
// - Override flag and forcing clear after five minutes.
// - Alarm, trip three, four: pulse 0.00-99.98 s.
// - 99.99 s means infinite; zero write releases.
`ifndef RELAY_OUT_CFG_SVH
`define RELAY_OUT_CFG_SVH
`define OFF_CTRL    32'h0000_0000
`define OFF_LATCH   32'h0000_0004
`define OFF_FVAL    32'h0000_0008
`define OFF_STAT    32'h0000_000C
`define OFF_DIRECT  32'h0000_0010
`define OFF_PULSE0  32'h0000_0014
`define OFF_MAP0    32'h0000_0020
`define CTRL_FORCE  0
`define CTRL_REL    1
`define STAT_FORCE  6
`define STAT_DIR    7
`define PULSE_RST   14'h0000
`define PULSE_INF   14'h270F
`define CLK_PERIOD_NS 100
`define TICK_MS     10
`define TICK_CYCLES ((`TICK_MS * 1000000) / `CLK_PERIOD_NS)
`define FORCE_MIN   5
`define FORCE_TICKS ((`FORCE_MIN * 60 * 1000) / `TICK_MS)
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2
`endif

// file: design/relay_out_pkg.sv
// Types shared by the relay output block and its bench.
// Assumes the constants header is compiled alongside.
package relay_out_pkg;
  typedef struct packed {
    logic        awvalid;
    logic [31:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [31:0] araddr;
    logic        rready;
  } axil_req_t;
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_t;
  typedef enum {
    SEL_CTRL, SEL_LATCH, SEL_FVAL, SEL_STAT, SEL_DIRECT, SEL_PULSE, SEL_MAP, SEL_NONE
  } reg_sel_t;
endpackage

// file: dv/relay_coil_model.sv
// Behavioural model of the relay coils and contacts that the block drives.
// Assumes registered coil levels on clk; each contact settles one cycle after its coil.
`timescale 1ns/10ps
module relay_coil_model (
  // Clock
  input  wire logic       clk,
  // Coil drives
  input  wire logic [3:0] trip_outputs,
  input  wire logic       alarm_output,
  input  wire logic       service_fault_output,
  // Contact states
  output logic [5:0]      contacts,
  output logic            alarm_nc
);
  always_ff @(posedge clk)
  begin
    contacts <= {service_fault_output, alarm_output, trip_outputs};
  end
  // The alarm relay has a change-over contact, so its rest side opens when it picks up.
  assign alarm_nc = ~contacts[4];
endmodule

// file: dv/testbench.sv
// Self-checking bench for the relay output block.
// Assumes the package and constants header are compiled first.
`timescale 1ns/10ps
`include "relay_out_cfg.svh"
module testbench;
  logic                     clk;
  logic                     rst_n;
  relay_out_pkg::axil_req_t req;
  relay_out_pkg::axil_rsp_t rsp;
  logic [15:0]              prot_sig;
  logic                     release_pin;
  logic [3:0]               trip_outputs;
  logic                     alarm_output;
  logic                     service_fault_output;
  logic                     stage_force;
  logic [5:0]               contacts;
  logic                     alarm_nc;
  logic [31:0]              rd;
  logic [1:0]               resp;
  int                       miscompares = 0;
  int                       n_checks = 0;
  int                       cycles = 0;

  // Short tick and timeout counts keep the run brief; expectations scale from them.
  relay_out #(.TICK_CYC(4), .FORCE_TCK(10)) dut (.clk(clk), .rst_n(rst_n), .bus_req(req),
    .bus_rsp(rsp), .prot_sig(prot_sig), .release_pin(release_pin),
    .trip_outputs(trip_outputs), .alarm_output(alarm_output),
    .service_fault_output(service_fault_output), .stage_force(stage_force));
  relay_coil_model coils (.clk(clk), .trip_outputs(trip_outputs),
    .alarm_output(alarm_output), .service_fault_output(service_fault_output),
    .contacts(contacts), .alarm_nc(alarm_nc));

  always #50 clk = ~clk;

  function automatic logic [5:0] outs();
    return {service_fault_output, alarm_output, trip_outputs};
  endfunction

  task automatic print_verdict;
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    do @(posedge clk); while (rsp.awready !== 1'b1);
    req.awvalid <= 1'b0;
    req.wvalid  <= 1'b0;
    do @(posedge clk); while (rsp.bvalid !== 1'b1);
    resp = rsp.bresp;
    req.bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd_reg(input logic [31:0] a);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do @(posedge clk); while (rsp.arready !== 1'b1);
    req.arvalid <= 1'b0;
    do @(posedge clk); while (rsp.rvalid !== 1'b1);
    rd = rsp.rdata;
    resp = rsp.rresp;
    req.rready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic hit(input logic [15:0] s);
    prot_sig <= s;
    @(posedge clk);
    prot_sig <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_reset;
    chk("reset outs", 32'h0000_0000, outs());
    rd_reg(`OFF_LATCH);
    chk("latch reset", 32'h0000_0000, rd);
    rd_reg(`OFF_CTRL);
    chk("ctrl reset", 32'h0000_0000, rd);
  endtask

  task automatic t_matrix;
    wr(`OFF_MAP0, 32'h0000_0008);
    wr(`OFF_MAP0 + 32'h0000_000C, 32'h0000_0080);
    wr(`OFF_MAP0 + 32'h0000_0010, 32'h0000_8000);
    wr(`OFF_MAP0 + 32'h0000_0014, 32'h0000_0001);
    prot_sig <= 16'h8089;
    repeat (2) @(posedge clk);
    chk("matrix outs", 32'h0000_0039, outs());
    rd_reg(`OFF_STAT);
    chk("status", 32'h0000_0039, rd);
    chk("contacts", 32'h0000_0039, contacts);
    chk("alarm rest side", 32'h0000_0000, alarm_nc);
    prot_sig <= 16'h0008;
    repeat (2) @(posedge clk);
    chk("follow", 32'h0000_0001, outs());
    prot_sig <= 16'h0000;
    repeat (2) @(posedge clk);
  endtask

  task automatic t_latch;
    wr(`OFF_MAP0 + 32'h0000_0004, 32'h0000_0004);
    wr(`OFF_LATCH, 32'h0000_0002);
    hit(16'h0004);
    chk("latched", 32'h0000_0002, outs());
    release_pin <= 1'b1;
    repeat (2) @(posedge clk);
    release_pin <= 1'b0;
    repeat (4) @(posedge clk);
    chk("pin release", 32'h0000_0000, outs());
    hit(16'h0004);
    wr(`OFF_CTRL, 32'h0000_0002);
    repeat (2) @(posedge clk);
    chk("ctrl release", 32'h0000_0000, outs());
  endtask

  task automatic t_force;
    wr(`OFF_FVAL, 32'h0000_003F);
    repeat (2) @(posedge clk);
    chk("fval ignored", 32'h0000_0000, outs());
    wr(`OFF_CTRL, 32'h0000_0001);
    chk("flag", 32'h0000_0001, stage_force);
    chk("fval kept clear", 32'h0000_0000, outs());
    wr(`OFF_FVAL, 32'h0000_002A);
    repeat (2) @(posedge clk);
    chk("forced", 32'h0000_002A, outs());
    rd_reg(`OFF_STAT);
    chk("forced status", 32'h0000_006A, rd);
    repeat (50) @(posedge clk);
    chk("flag timeout", 32'h0000_0000, stage_force);
    chk("force released", 32'h0000_0000, outs());
  endtask

  task automatic t_pulse;
    for (int i = 0; i < 3; i++)
    begin
      wr(`OFF_PULSE0 + 32'(4 * i), 32'h0000_0003);
      wr(`OFF_DIRECT, 32'(1 << i));
      @(posedge clk);
      chk("pulse on", 32'(1 << (i == 0 ? 4 : i + 1)), outs());
      repeat (4) @(posedge clk);
      chk("pulse held", 32'(1 << (i == 0 ? 4 : i + 1)), outs());
      repeat (12) @(posedge clk);
      chk("pulse off", 32'h0000_0000, outs());
    end
    wr(`OFF_PULSE0 + 32'h0000_0008, 32'h0000_3FFF);
    rd_reg(`OFF_PULSE0 + 32'h0000_0008);
    chk("pulse clamp", 32'h0000_270F, rd);
    wr(`OFF_PULSE0 + 32'h0000_0004, 32'h0000_270F);
    wr(`OFF_DIRECT, 32'h0000_0002);
    repeat (60) @(posedge clk);
    chk("infinite", 32'h0000_0004, outs());
    wr(`OFF_DIRECT, 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("host release", 32'h0000_0000, outs());
  endtask

  task automatic t_bus;
    rd_reg(32'h0000_0040);
    chk("unmapped rresp", `RESP_SLVERR, resp);
    chk("unmapped rdata", 32'h0000_0000, rd);
    wr(32'h0000_0040, 32'h0000_0001);
    chk("unmapped bresp", `RESP_SLVERR, resp);
    wr(`OFF_STAT, 32'h0000_003F);
    rd_reg(`OFF_STAT);
    chk("status read only", 32'h0000_0000, rd);
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      print_verdict;
    end
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    prot_sig = 16'h0000;
    release_pin = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_matrix;
    t_latch;
    t_force;
    t_pulse;
    t_bus;
    print_verdict;
  end
endmodule
